// ===== lpc_pkg.sv
// package of constants and carriers for the link status and pin config block
package lpc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_STATUS   = 8'h1c;
    localparam logic [7:0] IDX_PIN0     = 8'h1d;
    localparam logic [7:0] IDX_PIN12    = 8'h1e;
    localparam logic [7:0] IDX_INT_STAT = 8'h30;
    localparam logic [7:0] IDX_INT_MASK = 8'h31;
    localparam logic [7:0] IDX_PORT     = 8'h32;
    localparam int         IDX_SHIFT    = 2;

    ////////////////////////////////////////////////////////////////////////////
    // status bit positions
    localparam int ST_TX_DUAL = 5;
    localparam int ST_RX_DUAL = 4;
    localparam int ST_AUDIO   = 3;
    localparam int ST_SIGDET  = 1;
    localparam int ST_LOCK    = 0;

    // pin register fields
    localparam int REV_LSB      = 4;
    localparam int REV_W        = 4;
    localparam int PORT_SEL_BIT = 0;
    localparam int PORT_IN_LSB  = 4;
    localparam int NUM_PINS     = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [3:0] PIN0_RST   = 4'h3;
    localparam logic [7:0] PIN12_RST  = 8'h03;
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [7:0] REG_ZERO   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef enum logic [1:0] {
        MODE_FUNC,
        MODE_TRI,
        MODE_PIN_OUT,
        MODE_PIN_IN
    } lpc_mode_t;

    typedef struct packed {
        logic outVal;
        logic remoteCtrl;
        logic direction;
        logic enable;
    } lpc_pin_cfg_t;

    typedef struct packed {
        lpc_pin_cfg_t pin2;
        lpc_pin_cfg_t pin1;
    } lpc_pair_cfg_t;

    typedef struct packed {
        logic out;
        logic oe;
    } lpc_pin_drv_t;

    typedef struct packed {
        lpc_pin_cfg_t  pin0Cfg;
        lpc_pair_cfg_t pin12Cfg;
        logic          portSel;
        logic [7:0]    status;
        logic [7:0]    intStatus;
        logic [7:0]    intMask;
        logic [2:0]    pinInSel;
        logic [2:0]    pinOut;
        logic [2:0]    pinOe;
        logic [2:0]    altOut;
        logic [2:0]    altOe;
        logic          irq;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
    } lpc_state_t;

endpackage : lpc_pkg

// ===== lpc_pin_drive.sv
// decode of one pin's configuration nibble into a pad drive
`timescale 1ns/100ps

module lpc_pin_drive (
    input  lpc_pkg::lpc_pin_cfg_t cfg,
    input  wire logic             remoteVal,
    input  wire logic             funcVal,
    output lpc_pkg::lpc_pin_drv_t drv
);

    lpc_pkg::lpc_mode_t mode;

    always_comb begin
        // {direction, enable} picks the pad mode
        case ({cfg.direction, cfg.enable})
            2'b00:   mode = lpc_pkg::MODE_FUNC;
            2'b10:   mode = lpc_pkg::MODE_TRI;
            2'b01:   mode = lpc_pkg::MODE_PIN_OUT;
            default: mode = lpc_pkg::MODE_PIN_IN;
        endcase
        drv = '0;
        if (cfg.remoteCtrl) begin
            // remote value overrides every local mode
            drv.oe  = 1'b1;
            drv.out = remoteVal;
        end else begin
            case (mode)
                lpc_pkg::MODE_FUNC: begin
                    drv.oe  = 1'b1;
                    drv.out = funcVal;
                end
                lpc_pkg::MODE_PIN_OUT: begin
                    drv.oe  = 1'b1;
                    drv.out = cfg.outVal;
                end
                default: begin
                    drv.oe  = 1'b0;
                    drv.out = 1'b0;
                end
            endcase
        end
    end

endmodule : lpc_pin_drive

// ===== lpc_link_status.sv
// link status, pin configuration registers and interrupt logic behind apb
`timescale 1ns/100ps

// Overview of operation
// - status bit 5 shows transmit port dual-link mode active.
// - status bit 4 shows receive port dual-link mode active.
// - status bit 3 shows audio pll locked to incoming bit clock.
// - status bit 1 shows serial input signal detected.
// - status bit 0 shows clock recovery pll locked.
// - in dual-link mode lock needs both receive channels locked.
// - direction/enable 00 functional out, 10 tri-state, 01 pin out, 11 pin in.
// - remote control enable drives pin as output with remote value.
// - local output value driven only in pin-out mode without remote control.
// - port select moves pin 0 configuration to the alternate pin.
// - port select moves shared pin 1/2 configuration to alternate pins.
// - shared register holds pin 2 fields in bits 7-4, pin 1 in 3-0.
// - reset leaves pins 0 and 1 in input pin mode, pin 2 zero.
module lpc_link_status #(
    parameter int         ADDR_W        = 12,
    // arbitrary value, not a real part revision
    parameter logic [3:0] REVISION_CODE = 4'h5
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // link state from the receive and transmit paths
    input  wire logic              txDualLink,
    input  wire logic              rxDualLink,
    input  wire logic              audioPllLocked,
    input  wire logic              signalDetect,
    input  wire logic              cdrLock0,
    input  wire logic              cdrLock1,
    // pin values
    input  wire logic [2:0]        remoteVal,
    input  wire logic [2:0]        funcOut,
    input  wire logic [2:0]        pinIn,
    output logic      [2:0]        pinOut,
    output logic      [2:0]        pinOe,
    input  wire logic [2:0]        altPinIn,
    output logic      [2:0]        altPinOut,
    output logic      [2:0]        altPinOe,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addrHit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        addrHit = (a == (ADDR_W'(idx) << lpc_pkg::IDX_SHIFT));
    endfunction : addrHit

    function automatic logic knownAddr(input logic [ADDR_W-1:0] a);
        knownAddr = addrHit(a, lpc_pkg::IDX_STATUS)   || addrHit(a, lpc_pkg::IDX_PIN0)     ||
                    addrHit(a, lpc_pkg::IDX_PIN12)    || addrHit(a, lpc_pkg::IDX_INT_STAT) ||
                    addrHit(a, lpc_pkg::IDX_INT_MASK) || addrHit(a, lpc_pkg::IDX_PORT);
    endfunction : knownAddr

    // implemented bits of the status and interrupt layout
    function automatic logic [7:0] liveStatusMask();
        liveStatusMask                      = lpc_pkg::REG_ZERO;
        liveStatusMask[lpc_pkg::ST_TX_DUAL] = 1'b1;
        liveStatusMask[lpc_pkg::ST_RX_DUAL] = 1'b1;
        liveStatusMask[lpc_pkg::ST_AUDIO]   = 1'b1;
        liveStatusMask[lpc_pkg::ST_SIGDET]  = 1'b1;
        liveStatusMask[lpc_pkg::ST_LOCK]    = 1'b1;
    endfunction : liveStatusMask

    lpc_pkg::lpc_state_t   q;
    lpc_pkg::lpc_state_t   d;
    lpc_pkg::lpc_pin_cfg_t pinCfg [lpc_pkg::NUM_PINS];
    lpc_pkg::lpc_pin_drv_t pinDrv [lpc_pkg::NUM_PINS];
    logic [7:0]            liveStatus;
    logic [7:0]            rdByte;
    logic                  wrTake;
    logic                  lockNow;

    ////////////////////////////////////////////////////////////////////////////
    // pin decode, one per pin

    assign pinCfg[0] = q.pin0Cfg;
    assign pinCfg[1] = q.pin12Cfg.pin1;
    assign pinCfg[2] = q.pin12Cfg.pin2;

    for (genvar i = 0; i < lpc_pkg::NUM_PINS; i++) begin : g_pin
        lpc_pin_drive u_drive (
            .cfg       (pinCfg[i]),
            .remoteVal (remoteVal[i]),
            .funcVal   (funcOut[i]),
            .drv       (pinDrv[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        // dual link lock means both channels, a single one is not enough
        lockNow = rxDualLink ? (cdrLock0 && cdrLock1) : cdrLock0;
        liveStatus                      = lpc_pkg::REG_ZERO;
        liveStatus[lpc_pkg::ST_TX_DUAL] = txDualLink;
        liveStatus[lpc_pkg::ST_RX_DUAL] = rxDualLink;
        liveStatus[lpc_pkg::ST_AUDIO]   = audioPllLocked;
        liveStatus[lpc_pkg::ST_SIGDET]  = signalDetect;
        liveStatus[lpc_pkg::ST_LOCK]    = lockNow;

        // read mux, reserved bits zero
        rdByte = lpc_pkg::REG_ZERO;
        if (addrHit(paddr, lpc_pkg::IDX_STATUS)) begin
            rdByte = q.status;
        end else if (addrHit(paddr, lpc_pkg::IDX_PIN0)) begin
            rdByte = {REVISION_CODE, q.pin0Cfg};
        end else if (addrHit(paddr, lpc_pkg::IDX_PIN12)) begin
            rdByte = q.pin12Cfg;
        end else if (addrHit(paddr, lpc_pkg::IDX_INT_STAT)) begin
            rdByte = q.intStatus;
        end else if (addrHit(paddr, lpc_pkg::IDX_INT_MASK)) begin
            rdByte = q.intMask;
        end else if (addrHit(paddr, lpc_pkg::IDX_PORT)) begin
            rdByte[lpc_pkg::PORT_SEL_BIT] = q.portSel;
            rdByte[lpc_pkg::PORT_IN_LSB +: lpc_pkg::NUM_PINS] = q.pinInSel;
        end

        // a write lands only at the completing access edge
        wrTake = psel && penable && pwrite && q.pready && pstrb[0];

        d = q;
        if (!rst_n) begin
            d          = '0;
            d.pin0Cfg  = lpc_pkg::PIN0_RST;
            d.pin12Cfg = lpc_pkg::PIN12_RST;
            d.status   = lpc_pkg::STATUS_RST;
            d.intMask  = lpc_pkg::MASK_RST;
        end else if (ce) begin
            // no wait state: answer is prepared during setup
            d.pready  = psel && !penable;
            d.pslverr = psel && !penable && !knownAddr(paddr);
            if (psel && !penable && !pwrite) begin
                d.prdata = {24'h000000, rdByte};
            end

            // status and reserved bits have no write path
            d.status = liveStatus;
            if (wrTake && addrHit(paddr, lpc_pkg::IDX_PIN0)) begin
                // upper nibble is the revision code and is not stored
                d.pin0Cfg = pwdata[3:0];
            end else if (wrTake && addrHit(paddr, lpc_pkg::IDX_PIN12)) begin
                d.pin12Cfg = pwdata[7:0];
            end else if (wrTake && addrHit(paddr, lpc_pkg::IDX_INT_MASK)) begin
                d.intMask = pwdata[7:0] & liveStatusMask();
            end else if (wrTake && addrHit(paddr, lpc_pkg::IDX_PORT)) begin
                d.portSel = pwdata[lpc_pkg::PORT_SEL_BIT];
            end

            // any change of a status bit is an event; set beats clear
            d.intStatus = q.intStatus;
            if (wrTake && addrHit(paddr, lpc_pkg::IDX_INT_STAT)) begin
                d.intStatus = q.intStatus & ~pwdata[7:0];
            end
            d.intStatus = d.intStatus | (liveStatus ^ q.status);
            d.irq       = |(d.intStatus & d.intMask);

            // selected port gets the decoded drive, the other is parked
            for (int i = 0; i < lpc_pkg::NUM_PINS; i++) begin
                d.pinOut[i] = q.portSel ? 1'b0 : pinDrv[i].out;
                d.pinOe[i]  = q.portSel ? 1'b0 : pinDrv[i].oe;
                d.altOut[i] = q.portSel ? pinDrv[i].out : 1'b0;
                d.altOe[i]  = q.portSel ? pinDrv[i].oe : 1'b0;
            end
            d.pinInSel = q.portSel ? altPinIn : pinIn;
        end
    end

    always_ff @(posedge sys_clk) begin
        q <= d;
    end

    assign prdata    = q.prdata;
    assign pready    = q.pready;
    assign pslverr   = q.pslverr;
    assign pinOut    = q.pinOut;
    assign pinOe     = q.pinOe;
    assign altPinOut = q.altOut;
    assign altPinOe  = q.altOe;
    assign irq       = q.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_tx_dual;
        ce |=> q.status[lpc_pkg::ST_TX_DUAL] == $past(txDualLink);
    endproperty
    a_tx_dual: assert property (p_tx_dual) else $error("tx dual status wrong");

    property p_rx_dual;
        ce |=> q.status[lpc_pkg::ST_RX_DUAL] == $past(rxDualLink);
    endproperty
    a_rx_dual: assert property (p_rx_dual) else $error("rx dual status wrong");

    property p_audio;
        ce ##0 audioPllLocked |=> q.status[lpc_pkg::ST_AUDIO];
    endproperty
    a_audio: assert property (p_audio) else $error("audio lock not shown");

    property p_sigdet;
        (ce && !signalDetect)[*2] |-> !q.status[lpc_pkg::ST_SIGDET];
    endproperty
    a_sigdet: assert property (p_sigdet) else $error("signal detect stuck");

    property p_lock_single;
        ce && !rxDualLink |=> q.status[lpc_pkg::ST_LOCK] == $past(cdrLock0);
    endproperty
    a_lock_single: assert property (p_lock_single) else $error("lock wrong");

    property p_lock_dual;
        ce && rxDualLink && (cdrLock0 != cdrLock1) |=> !q.status[lpc_pkg::ST_LOCK];
    endproperty
    a_lock_dual: assert property (p_lock_dual) else $error("half lock shown");

    property p_tristate;
        ce && !q.portSel && !q.pin12Cfg.pin1.remoteCtrl &&
            q.pin12Cfg.pin1.direction && !q.pin12Cfg.pin1.enable |=> !pinOe[1];
    endproperty
    a_tristate: assert property (p_tristate) else $error("tri-state driven");

    property p_remote;
        ce && !q.portSel && q.pin0Cfg.remoteCtrl
            |=> pinOe[0] && pinOut[0] == $past(remoteVal[0]);
    endproperty
    a_remote: assert property (p_remote) else $error("remote value not driven");

    property p_local;
        ce && !q.portSel && !q.pin0Cfg.remoteCtrl && !q.pin0Cfg.direction &&
            q.pin0Cfg.enable |=> pinOe[0] && pinOut[0] == $past(q.pin0Cfg.outVal);
    endproperty
    a_local: assert property (p_local) else $error("local value not driven");

    property p_alt_port;
        ce && q.portSel |=> pinOe == 3'h0 && altPinOe[0] == $past(pinDrv[0].oe);
    endproperty
    a_alt_port: assert property (p_alt_port) else $error("port select ignored");

    property p_alt_pair;
        ce && q.portSel && q.pin12Cfg.pin2.remoteCtrl |=> altPinOe[2];
    endproperty
    a_alt_pair: assert property (p_alt_pair) else $error("alt pin 2 idle");

    sequence s_read(logic [7:0] idx);
        ce && psel && !penable && !pwrite && addrHit(paddr, idx) ##1 psel && penable;
    endsequence

    property p_pair_read;
        s_read(lpc_pkg::IDX_PIN12) |-> prdata == {24'h000000, $past(q.pin12Cfg)};
    endproperty
    a_pair_read: assert property (p_pair_read) else $error("pair layout wrong");

    property p_reset;
        disable iff (1'b0)
        !rst_n |=> q.pin0Cfg == lpc_pkg::PIN0_RST && q.pin12Cfg == lpc_pkg::PIN12_RST;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset config");

    property p_status_read;
        s_read(lpc_pkg::IDX_STATUS) |-> prdata[31:6] == 26'h0 && !prdata[2];
    endproperty
    a_status_read: assert property (p_status_read) else $error("reserved not zero");

    property p_rev;
        s_read(lpc_pkg::IDX_PIN0) |-> prdata[lpc_pkg::REV_LSB +: lpc_pkg::REV_W] == REVISION_CODE;
    endproperty
    a_rev: assert property (p_rev) else $error("revision code wrong");

    property p_ready;
        ce && psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");

    property p_ready_drop;
        ce && pready |=> !pready;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready held too long");

    property p_err;
        ce && psel && !penable && !knownAddr(paddr) |=> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access accepted");

    property p_no_err;
        ce && psel && !penable && knownAddr(paddr) |=> !pslverr;
    endproperty
    a_no_err: assert property (p_no_err) else $error("mapped access refused");

    property p_pair_write;
        ce && wrTake && addrHit(paddr, lpc_pkg::IDX_PIN12)
            |=> q.pin12Cfg == $past(pwdata[7:0]);
    endproperty
    a_pair_write: assert property (p_pair_write) else $error("pair write lost");

    property p_w1c;
        ce && wrTake && addrHit(paddr, lpc_pkg::IDX_INT_STAT) && liveStatus == q.status
            |=> q.intStatus == ($past(q.intStatus) & ~$past(pwdata[7:0]));
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

    property p_set_wins;
        ce && liveStatus != q.status
            |=> (q.intStatus & (q.status ^ $past(q.status))) == (q.status ^ $past(q.status));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("status event lost");

    property p_irq;
        ce |=> irq == |(q.intStatus & q.intMask);
    endproperty
    a_irq: assert property (p_irq) else $error("irq level wrong");

    property p_mask_impl;
        ce |=> (q.intMask & ~liveStatusMask()) == lpc_pkg::REG_ZERO;
    endproperty
    a_mask_impl: assert property (p_mask_impl) else $error("unused mask bit stored");

    // a frozen block must not even move its bus answer
    property p_freeze;
        !ce |=> $stable(q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with ce low");

    property p_pin2_func;
        ce && !q.portSel && !q.pin12Cfg.pin2.remoteCtrl && !q.pin12Cfg.pin2.direction &&
            !q.pin12Cfg.pin2.enable |=> pinOe[2] && pinOut[2] == $past(funcOut[2]);
    endproperty
    a_pin2_func: assert property (p_pin2_func) else $error("functional drive lost");

    property p_pin_in;
        ce && !q.portSel && !q.pin0Cfg.remoteCtrl && q.pin0Cfg.direction &&
            q.pin0Cfg.enable |=> !pinOe[0];
    endproperty
    a_pin_in: assert property (p_pin_in) else $error("input pin driven");

    property p_alt_parked;
        ce && !q.portSel |=> altPinOe == 3'h0 && altPinOut == 3'h0;
    endproperty
    a_alt_parked: assert property (p_alt_parked) else $error("alt pins not parked");

endmodule : lpc_link_status

// ===== lpc_remote_model.sv
// behavioural model of the remote serializer and the link state it causes
`timescale 1ns/100ps

module lpc_remote_model (
    input  wire logic       sys_clk,
    input  wire logic [5:0] linkCmd,
    input  wire logic [2:0] remoteCmd,
    output logic            txDualLink,
    output logic            rxDualLink,
    output logic            audioPllLocked,
    output logic            signalDetect,
    output logic            cdrLock0,
    output logic            cdrLock1,
    output logic      [2:0] remoteVal
);
    ////////////////////////////////////////////////////////////////////////////
    // link state moves only just after an edge, like a real recovered domain
    initial begin
        {txDualLink, rxDualLink, audioPllLocked, signalDetect, cdrLock0, cdrLock1} = 6'h00;
        remoteVal = 3'h0;
    end
    always @(posedge sys_clk) begin
        {txDualLink, rxDualLink, audioPllLocked, signalDetect, cdrLock0, cdrLock1} <= linkCmd;
        remoteVal <= remoteCmd;
    end
endmodule : lpc_remote_model

// ===== tb_lpc_link_status.sv
// self-checking bench for the link status and pin config block
`timescale 1ns/100ps

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb_lpc_link_status;
    localparam logic [3:0] REV = 4'ha; // arbitrary value
    logic        sys_clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        txD, rxD, aud, sig, l0, l1;
    logic [2:0]  remoteVal, funcOut, pinIn, pinOut, pinOe, altPinIn, altPinOut, altPinOe;
    logic [5:0]  linkCmd;
    logic [2:0]  remoteCmd;
    int          n_mismatch, samples_checked;

    ////////////////////////////////////////////////////////////////////////////
    lpc_link_status #(.ADDR_W(12), .REVISION_CODE(REV)) lpc_link_status_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txDualLink(txD), .rxDualLink(rxD),
        .audioPllLocked(aud), .signalDetect(sig), .cdrLock0(l0), .cdrLock1(l1),
        .remoteVal(remoteVal), .funcOut(funcOut), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .altPinIn(altPinIn), .altPinOut(altPinOut), .altPinOe(altPinOe),
        .irq(irq));
    lpc_remote_model lpc_remote_model_i (
        .sys_clk(sys_clk), .linkCmd(linkCmd), .remoteCmd(remoteCmd), .txDualLink(txD),
        .rxDualLink(rxD), .audioPllLocked(aud), .signalDetect(sig), .cdrLock0(l0),
        .cdrLock1(l1), .remoteVal(remoteVal));

    always #25 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////
    // apb master: waits on pready, never assumes a latency
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] strb, output logic [7:0] rd, output logic err);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        pstrb <= strb;
        paddr <= 12'(idx) << lpc_pkg::IDX_SHIFT;
        pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, idx, d, 4'hf, r, e);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, 4'hf, r, e);
        `CHK(nm, exp, r)
        `CHK("pslverr", 1'b0, e)
    endtask : rdchk

    // expected {oe, out} of one pin from its nibble
    function automatic logic [1:0] expDrv(input logic [3:0] c, input logic f, input logic r);
        if (c[2]) return {1'b1, r};
        case (c[1:0])
            2'b00: return {1'b1, f};
            2'b01: return {1'b1, c[3]};
            default: return 2'b00;
        endcase
    endfunction : expDrv

    // out is only judged where the pad drives; a parked pad may show anything
    task automatic chkPins(input logic [3:0] c0, c1, c2, input logic sel);
        logic [3:0] cf [3];
        logic [2:0] eo, ev;
        logic [1:0] d;
        cf[0] = c0;
        cf[1] = c1;
        cf[2] = c2;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 3; i++) begin
            d = expDrv(cf[i], funcOut[i], remoteVal[i]);
            eo[i] = d[1];
            ev[i] = d[0];
        end
        if (sel) begin
            `CHK("altPinOe", eo, altPinOe)
            `CHK("altPinOut", ev & eo, altPinOut & eo)
            `CHK("pinOe", 3'h0, pinOe)
        end else begin
            `CHK("pinOe", eo, pinOe)
            `CHK("pinOut", ev & eo, pinOut & eo)
            `CHK("altPinOe", 3'h0, altPinOe)
        end
    endtask : chkPins

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////
    logic [5:0] stim [6] = '{6'b100000, 6'b010010, 6'b010011, 6'b000010, 6'b001000, 6'b000100};
    logic [7:0] expSt [6] = '{8'h20, 8'h10, 8'h11, 8'h01, 8'h08, 8'h02};
    logic [3:0] cfgs [6] = '{4'h8, 4'ha, 4'h9, 4'hb, 4'h4, 4'h1};

    initial begin
        logic [7:0] r;
        logic e;
        sys_clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        funcOut = 3'b101;
        pinIn = 3'b001;
        altPinIn = 3'b110;
        linkCmd = 6'h00;
        remoteCmd = 3'b011;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        // reset values and read-only places
        rdchk("status", lpc_pkg::IDX_STATUS, 8'h00);
        rdchk("pin0", lpc_pkg::IDX_PIN0, {REV, 4'h3});
        rdchk("pin12", lpc_pkg::IDX_PIN12, 8'h03);
        rdchk("mask", lpc_pkg::IDX_INT_MASK, 8'h00);
        chkPins(4'h3, 4'h3, 4'h0, 1'b0);
        wr(lpc_pkg::IDX_STATUS, 8'hff);
        rdchk("status ro", lpc_pkg::IDX_STATUS, 8'h00);
        wr(lpc_pkg::IDX_PIN0, 8'hf0);
        rdchk("rev ro", lpc_pkg::IDX_PIN0, {REV, 4'h0});
        apb(1'b0, 8'h10, 8'h00, 4'hf, r, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 8'h00, r)
        apb(1'b1, lpc_pkg::IDX_PIN12, 8'hff, 4'h0, r, e);
        rdchk("no strobe", lpc_pkg::IDX_PIN12, 8'h03);
        // status bits, each cause alone; dual lock needs both channels
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk) linkCmd <= stim[i];
            repeat (3) @(posedge sys_clk);
            rdchk("status", lpc_pkg::IDX_STATUS, expSt[i]);
        end
        // interrupt: set, mask, unmask, clear
        wr(lpc_pkg::IDX_INT_STAT, 8'hff);
        rdchk("intStatus clr", lpc_pkg::IDX_INT_STAT, 8'h00);
        wr(lpc_pkg::IDX_INT_MASK, 8'hff);
        rdchk("mask impl", lpc_pkg::IDX_INT_MASK, 8'h3b);
        wr(lpc_pkg::IDX_INT_MASK, 8'h02);
        `CHK("irq idle", 1'b0, irq)
        @(posedge sys_clk) linkCmd <= 6'b000000;
        repeat (4) @(posedge sys_clk);
        `CHK("irq set", 1'b1, irq)
        rdchk("intStatus", lpc_pkg::IDX_INT_STAT, 8'h02);
        wr(lpc_pkg::IDX_INT_MASK, 8'h00);
        repeat (2) @(posedge sys_clk);
        `CHK("irq masked", 1'b0, irq)
        wr(lpc_pkg::IDX_INT_MASK, 8'h02);
        repeat (2) @(posedge sys_clk);
        `CHK("irq unmasked", 1'b1, irq)
        wr(lpc_pkg::IDX_INT_STAT, 8'h02);
        repeat (2) @(posedge sys_clk);
        `CHK("irq cleared", 1'b0, irq)
        // clock enable low: the new event waits until it comes back
        ce <= 1'b0;
        linkCmd <= 6'b000100;
        repeat (4) @(posedge sys_clk);
        `CHK("irq frozen", 1'b0, irq)
        ce <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `CHK("irq thawed", 1'b1, irq)
        wr(lpc_pkg::IDX_INT_STAT, 8'h02);
        // every decode on every pin, on both ports
        for (int s = 0; s < 2; s++) begin
            wr(lpc_pkg::IDX_PORT, 8'(s));
            rdchk("port", lpc_pkg::IDX_PORT, s ? 8'h61 : 8'h10);
            for (int i = 0; i < 6; i++) begin
                wr(lpc_pkg::IDX_PIN0, {4'h0, cfgs[i]});
                wr(lpc_pkg::IDX_PIN12, {cfgs[(i + 2) % 6], cfgs[(i + 1) % 6]});
                rdchk("pin12", lpc_pkg::IDX_PIN12, {cfgs[(i + 2) % 6], cfgs[(i + 1) % 6]});
                chkPins(cfgs[i], cfgs[(i + 1) % 6], cfgs[(i + 2) % 6], s[0]);
            end
        end
        close_out();
    end

    // watchdog: the sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        close_out();
    end
endmodule : tb_lpc_link_status
